// ### hw/sci_top.sv
// Asynchronous serial interface with AXI4-Lite register slave
`timescale 1ns/1ns
module sci_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // AXI4-Lite write channels
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read channels
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Serial link and interrupt
  input wire logic RXD,
  output logic TXD_O,
  output logic TXD_OE,
  output logic IRQ
);
  import sci_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  sci_pkg::ctrl_t ctrl_q;
  logic [ST_W-1:0] mask_q, stat_q, ev;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic aw_have_q, w_have_q, do_wr, rd_take, rd_stat, rd_data, wr_data;
  logic [DATA_W-1:0] rx_hold_q, tx_hold_q;
  logic rx_unread_q, tx_full_q, tx_load, wake_p;
  tx_state_t tx_st_q;
  rx_state_t rx_st_q;
  logic [10:0] tx_sr_q, rx_sr_q;
  logic [15:0] tx_cnt_q, rx_cnt_q;
  logic [3:0] tx_bit_q, rx_bit_q, nbits, idle_bits_q;
  logic rxd_m_q, rxd_s_q, idle_arm_q;
  logic [8:0] tx_d, rx_d;
  logic rx_last, rx_par_bad;

  assign nbits = ctrl_q.word_len ? FRAME_LONG : FRAME_SHORT;

  //////////////////////////////////////////////////////////////////////////
  // AXI write path: address and data taken in either order
  assign do_wr = aw_have_q && w_have_q && !BVALID;
  assign wr_data = do_wr && aw_q == DATA_OFS && ws_q[0];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_q <= AWADDR;
        aw_have_q <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wd_q <= WDATA;
        ws_q <= WSTRB;
        w_have_q <= 1'b1;
        WREADY <= 1'b0;
      end
      if (do_wr) begin
        BVALID <= 1'b1;
        BRESP <= (aw_q == CTRL_OFS || aw_q == MASK_OFS ||
                  aw_q == DATA_OFS) ? RESP_OKAY : RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI read path; reads of status and data have side effects
  assign rd_take = ARVALID && ARREADY;
  assign rd_stat = rd_take && ARADDR == STAT_OFS;
  assign rd_data = rd_take && ARADDR == DATA_OFS;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (rd_take) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= RESP_OKAY;
      case (ARADDR)
        CTRL_OFS: RDATA <= {ctrl_q.baud_div, 8'h00, ctrl_q[7:0]};
        MASK_OFS: RDATA <= {25'h000_0000, mask_q};
        STAT_OFS: RDATA <= {25'h000_0000, stat_q | ev};
        DATA_OFS: RDATA <= {23'h00_0000, rx_hold_q};
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control and mask registers; sleep is cleared by the wakeup logic
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else begin
      if (do_wr && aw_q == CTRL_OFS) begin
        if (ws_q[0]) ctrl_q[7:0] <= wd_q[7:0];
        if (ws_q[2]) ctrl_q.baud_div[7:0] <= wd_q[23:16];
        if (ws_q[3]) ctrl_q.baud_div[15:8] <= wd_q[31:24];
      end else if (wake_p) begin
        ctrl_q.rx_sleep <= 1'b0;
      end
      if (do_wr && aw_q == MASK_OFS && ws_q[0]) begin
        // One receive enable drives both receive bits
        // Overrun has no enable of its own: bit 3 mirrors bit 2
        mask_q <= {wd_q[6:4], wd_q[2], wd_q[2], wd_q[1:0]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky status; an event in the reading cycle survives the clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat_q <= '0;
      IRQ <= 1'b0;
    end else begin
      stat_q <= (rd_stat ? '0 : stat_q) | ev;
      // Each flag reaches the line only through its enable
      IRQ <= |(((rd_stat ? '0 : stat_q) | ev) & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit holding register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_hold_q <= '0;
      tx_full_q <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_hold_q <= wd_q[8:0];
        tx_full_q <= 1'b1;
      end else if (tx_load) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // Data bits with optional parity in the top data bit
  always_comb begin
    tx_d = tx_hold_q;
    if (!ctrl_q.word_len) tx_d[8] = 1'b1;
    if (ctrl_q.parity_en && ctrl_q.word_len)
      tx_d[8] = ^tx_hold_q[7:0] ^ ctrl_q.parity_odd;
    if (ctrl_q.parity_en && !ctrl_q.word_len)
      tx_d[7] = ^tx_hold_q[6:0] ^ ctrl_q.parity_odd;
  end

  assign tx_load = tx_st_q == TX_IDLE && ctrl_q.tx_on &&
                   !ctrl_q.break_send && tx_full_q;

  //////////////////////////////////////////////////////////////////////////
  // Transmitter: start, data LSB first, stop; break sent between frames
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_st_q <= TX_IDLE;
      tx_sr_q <= 11'h7FF;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      TXD_O <= 1'b1;
      TXD_OE <= 1'b0;
    end else begin
      TXD_OE <= ctrl_q.tx_on;
      case (tx_st_q)
        TX_IDLE: begin
          TXD_O <= 1'b1;
          tx_bit_q <= 4'h0;
          tx_cnt_q <= ctrl_q.baud_div;
          if (ctrl_q.tx_on && ctrl_q.break_send) begin
            tx_sr_q <= 11'h000;
            tx_st_q <= TX_RUN;
          end else if (tx_load) begin
            tx_sr_q <= {1'b1, tx_d, 1'b0};
            tx_st_q <= TX_RUN;
          end
        end
        TX_RUN: begin
          TXD_O <= tx_sr_q[0];
          if (tx_cnt_q == 16'h0000) begin
            tx_cnt_q <= ctrl_q.baud_div;
            tx_sr_q <= {1'b1, tx_sr_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == nbits - 4'h1) tx_st_q <= TX_IDLE;
          end else begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive line synchroniser
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= RXD;
      rxd_s_q <= rxd_m_q;
    end
  end

  // Decode of a frame as its stop bit is sampled
  always_comb begin
    rx_d = ctrl_q.word_len ? rx_sr_q[9:1] : {1'b0, rx_sr_q[8:1]};
    rx_last = ctrl_q.word_len ? rx_sr_q[9] : rx_sr_q[8];
    rx_par_bad = ctrl_q.parity_en && (ctrl_q.word_len ?
      (^rx_sr_q[9:1] != ctrl_q.parity_odd) :
      (^rx_sr_q[8:1] != ctrl_q.parity_odd));
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver: mid-bit sampling, idle-line count and wakeup
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_st_q <= RX_IDLE;
      rx_sr_q <= 11'h000;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      idle_bits_q <= 4'h0;
      idle_arm_q <= 1'b0;
      rx_hold_q <= '0;
      rx_unread_q <= 1'b0;
      ev <= '0;
      wake_p <= 1'b0;
    end else begin
      ev <= '0;
      wake_p <= 1'b0;
      if (tx_load) ev[ST_TXE] <= 1'b1;
      if (tx_st_q == TX_RUN && tx_cnt_q == 16'h0000 &&
          tx_bit_q == nbits - 4'h1 && !tx_full_q && !ctrl_q.break_send)
        ev[ST_TXC] <= 1'b1;
      if (rd_data) rx_unread_q <= 1'b0;
      if (!ctrl_q.rx_on) begin
        rx_st_q <= RX_IDLE;
        idle_arm_q <= 1'b0;
      end else begin
        case (rx_st_q)
          RX_IDLE: begin
            rx_bit_q <= 4'h0;
            if (!rxd_s_q) begin
              rx_cnt_q <= {1'b0, ctrl_q.baud_div[15:1]};
              idle_bits_q <= 4'h0;
              rx_st_q <= RX_START;
            end else if (idle_arm_q) begin
              // One whole frame time of high line means idle
              if (rx_cnt_q == 16'h0000) begin
                rx_cnt_q <= ctrl_q.baud_div;
                idle_bits_q <= idle_bits_q + 4'h1;
                if (idle_bits_q == nbits - 4'h1) begin
                  idle_arm_q <= 1'b0;
                  ev[ST_IDLE] <= 1'b1;
                  if (ctrl_q.rx_sleep && !ctrl_q.wake_addr)
                    wake_p <= 1'b1;
                end
              end else begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
              end
            end
          end
          RX_START, RX_RUN: begin
            if (rx_cnt_q == 16'h0000) begin
              rx_cnt_q <= ctrl_q.baud_div;
              rx_sr_q[rx_bit_q] <= rxd_s_q;
              rx_bit_q <= rx_bit_q + 4'h1;
              rx_st_q <= RX_RUN;
              // A start bit gone high again was only a glitch
              if (rx_st_q == RX_START && rxd_s_q) rx_st_q <= RX_IDLE;
              if (rx_bit_q == nbits - 4'h1) begin
                rx_st_q <= RX_IDLE;
                idle_arm_q <= 1'b1;
                rx_cnt_q <= ctrl_q.baud_div;
                if (!ctrl_q.rx_sleep ||
                    (ctrl_q.wake_addr && rx_last)) begin
                  if (ctrl_q.rx_sleep) wake_p <= 1'b1;
                  ev[ST_FE] <= !rxd_s_q;
                  ev[ST_PF] <= rx_par_bad;
                  if (rx_unread_q && !rd_data) begin
                    ev[ST_OVR] <= 1'b1;
                  end else begin
                    rx_hold_q <= rx_d;
                    rx_unread_q <= 1'b1;
                    ev[ST_RXF] <= 1'b1;
                  end
                end
              end
            end else begin
              rx_cnt_q <= rx_cnt_q - 16'h0001;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

endmodule : sci_top

// ### inc/sci_pkg.sv
// Constants, register map and field types of the serial interface
//
// Operation
// - Word length bit 0 selects 10-bit frames, 1 selects 11-bit frames.
// - Wakeup select 0 wakes on idle line, 1 on last data bit set.
// - Buffer empty flag interrupts only while its enable is 1.
// - Transmit complete flag interrupts only while its enable is 1.
// - One receive enable gates both buffer full and overrun interrupts.
// - Idle-line flag interrupts only while its enable is 1.
// - Transmitter off frees the pin; on, only the transmitter drives it.
// - Receiver works only while its enable bit is 1.
// - Sleeping receiver ignores frames until the selected wakeup occurs.
// - Break bit sends break frames after current frame; clearing resumes.
// - Framing fault on bad stop bit or received break.
// - Parity fault when received parity mismatches, clear otherwise; here it stays set until status is read.
// - Data word has nine bits in 8:0; bits 15:9 read zero.
// - Data reads return receive holding; writes load transmit holding.
// - Ninth data bit matters only in nine-bit operation.
package sci_pkg;

  // Byte addresses of the register words
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] DATA_OFS = 8'h0C;

  // Frame lengths and data width
  localparam logic [3:0] FRAME_SHORT = 4'hA;
  localparam logic [3:0] FRAME_LONG = 4'hB;
  localparam int DATA_W = 9;

  // Reset values
  localparam logic [15:0] BAUD_DIV_RST = 16'h0057;
  localparam logic [6:0] MASK_RST = 7'h00;

  // Status and mask bit positions
  localparam int ST_TXE = 0;
  localparam int ST_TXC = 1;
  localparam int ST_RXF = 2;
  localparam int ST_OVR = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_FE = 5;
  localparam int ST_PF = 6;
  localparam int ST_W = 7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control word, low bits of CTRL
  typedef struct packed {
    logic [15:0] baud_div;
    logic parity_odd;
    logic parity_en;
    logic break_send;
    logic rx_sleep;
    logic rx_on;
    logic tx_on;
    logic wake_addr;
    logic word_len;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{baud_div: BAUD_DIV_RST, default: 1'b0};

  typedef enum logic [0:0] {TX_IDLE, TX_RUN} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_RUN} rx_state_t;

endpackage : sci_pkg

// ### verification/sci_top_asserts.sv
// Concurrent checks on the bus, pin and interrupt ports of sci_top
`timescale 1ns/1ns
module sci_top_asserts
  import sci_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register bus
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [7:0] ARADDR,
  input wire logic RVALID,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  // Pin and interrupt
  input wire logic TXD_OE,
  input wire logic IRQ
);
  logic [7:0] aw_q;
  logic [7:0] ar_q;
  logic [31:0] wd_q;
  logic [6:0] mask_q;
  logic tx_on_q;
  logic calm;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////
  // No write held: shadows then match the device, IRQ lag aside
  assign calm = AWREADY && WREADY && !BVALID;
  // Shadow of enables, committed only at the write response
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_q <= '0;
      wd_q <= '0;
      ar_q <= '0;
      mask_q <= '0;
      tx_on_q <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) aw_q <= AWADDR;
      if (WVALID && WREADY) wd_q <= WDATA;
      if (ARVALID && ARREADY) ar_q <= ARADDR;
      if (BVALID && BREADY && aw_q == MASK_OFS) mask_q <= wd_q[6:0];
      if (BVALID && BREADY && aw_q == CTRL_OFS) tx_on_q <= wd_q[2];
    end
  end
  AST_RD_NEXT: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  AST_AR_HELD: assert property (
    RVALID |-> !ARREADY)
    else $error("read taken while one is held");
  AST_WR_DONE: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer late");
  AST_B_FREE: assert property (
    BVALID && BREADY |=> !BVALID ##[0:1] (AWREADY && WREADY))
    else $error("write slot not freed");
  AST_DATA_TOP: assert property (
    RVALID && ar_q == DATA_OFS |-> RDATA[31:9] == '0)
    else $error("data word upper bits set");
  AST_BAD_ADDR: assert property (
    RVALID && ar_q > DATA_OFS |-> RRESP == RESP_SLVERR && RDATA == '0)
    else $error("unmapped read not refused");
  AST_IRQ_MASK: assert property (
    calm && mask_q == '0 && $past(mask_q) == '0 |-> !IRQ)
    else $error("interrupt with all enables off");
  AST_TX_PIN: assert property (
    calm && $stable(tx_on_q) |-> TXD_OE == tx_on_q)
    else $error("pin drive differs from enable");
  // Main scenarios reached
  COV_WRITE: cover property (BVALID && BREADY);
  COV_STAT: cover property (RVALID && ar_q == STAT_OFS);
  COV_IRQ: cover property ($rose(IRQ));
endmodule : sci_top_asserts

bind sci_top sci_top_asserts i_sci_top_asserts (.*);

// ### verification/sci_remote.sv
// Remote serial port model: drives RXD, samples the transmit pin
`timescale 1ns/1ns
module sci_remote #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic clk,
  // Serial link
  output logic rxd,
  input wire logic txd,
  input wire logic txd_oe
);
  logic line;
  // A released pin reads as pulled high, never as a stale level
  assign line = txd_oe ? txd : 1'b1;
  initial rxd = 1'b1;
  ////////////////////////////////////////
  // Start bit, data LSB first, then the stop level asked for
  task automatic send(input logic [8:0] d, input int nd, input logic s);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nd; i++) begin
      rxd <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= s;
    repeat (BIT_CLKS) @(posedge clk);
    rxd <= 1'b1;
  endtask : send
  // Data bits in f[nd-1:0], stop level in f[nd], sampled mid-bit
  task automatic grab(input int nd, output logic [9:0] f);
    f = '0;
    for (int n = 0; n < 999 && line !== 1'b0; n++) @(posedge clk);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i <= nd; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      f[i] = line;
    end
  endtask : grab
endmodule : sci_remote

// ### verification/sci_top_tb_top.sv
// Self-checking bench for sci_top against the remote port model
`timescale 1ns/1ns
module sci_top_tb_top
  import sci_pkg::*;
;
  localparam int BIT = 16;
  logic CLK, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, RXD, TXD_O, TXD_OE, IRQ;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, v;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [9:0] f;
  logic [1:0] rr;
  int miscompares = 0;
  int samples_checked = 0;
  // Device and far side; bit time 16 clocks (divisor 15)
  sci_top i_sci_top (.*);
  sci_remote #(.BIT_CLKS(BIT)) i_sci_remote (.clk(CLK), .rxd(RXD),
    .txd(TXD_O), .txd_oe(TXD_OE));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, e, g);
    end
  endtask : chk
  // BREADY and RREADY stay high, so no double drive between calls
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      n++;
    end while (!BVALID && n < 50);
    chk("b", {29'h0, 1'b1, RESP_OKAY}, {29'h0, BVALID, BRESP});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      n++;
    end while (!RVALID && n < 50);
    v = RVALID ? RDATA : 32'hDEAD_0001;
    rr = RRESP;
  endtask : rd
  // Receive one frame, then check IRQ, receive status bits and the data
  task automatic rxc(input logic [8:0] d, input int nd, input logic s,
      input logic [7:0] e, input logic q);
    i_sci_remote.send(d, nd, s);
    repeat (4) @(posedge CLK);
    chk("irq", 32'(q), 32'(IRQ));
    rd(STAT_OFS);
    chk("stat", {24'h0, e}, v & 32'h0000_006C);
    rd(DATA_OFS);
    if (e[2])
      chk("data", nd == 9 ? {23'h0, d} : {24'h0, d[7:0]}, v);
  endtask : rxc
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Run needs some 3200 cycles
  initial begin
    repeat (40000) @(posedge CLK);
    miscompares++;
    report_and_stop();
  end
  initial begin
    RESETN = 1'b0;
    {AWVALID, WVALID, ARVALID, AWADDR, ARADDR, WDATA} = '0;
    {BREADY, RREADY, WSTRB} = 6'h3F;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    chk("oe", 32'h0, 32'(TXD_OE));
    rd(CTRL_OFS);
    chk("ctrl", {CTRL_RST[23:8], 8'h00, CTRL_RST[7:0]}, v);
    rd(MASK_OFS);
    chk("mask", {25'h0, MASK_RST}, v);
    $display("reset test done");
    // Transmit 8-bit: 0xA5 framed with stop bit high, both TX flags reach IRQ
    wr(MASK_OFS, 32'h0000_0003);
    wr(CTRL_OFS, 32'h000F_000C);
    @(posedge CLK);
    chk("oe", 32'h1, 32'(TXD_OE));
    wr(DATA_OFS, 32'h0000_00A5);
    i_sci_remote.grab(8, f);
    chk("tx8", 32'h0000_01A5, 32'(f));
    repeat (10) @(posedge CLK);
    chk("irq", 32'h1, 32'(IRQ));
    rd(STAT_OFS);
    chk("txst", 32'h3, v & 32'h3);
    @(posedge CLK);
    chk("irq", 32'h0, 32'(IRQ));
    $display("transmit test done");
    // Receive 8-bit: data, framing, parity, receiver off, overrun
    wr(MASK_OFS, 32'h0000_0004);
    rxc(9'h03C, 8, 1'b1, 8'h04, 1'b1);
    rxc(9'h0F0, 8, 1'b0, 8'h24, 1'b1);
    wr(CTRL_OFS, 32'h000F_004C);
    rxc(9'h001, 8, 1'b1, 8'h44, 1'b1);
    rxc(9'h081, 8, 1'b1, 8'h04, 1'b1);
    wr(CTRL_OFS, 32'h000F_0004);
    rxc(9'h055, 8, 1'b1, 8'h00, 1'b0);
    wr(CTRL_OFS, 32'h000F_000C);
    wr(MASK_OFS, 32'h0000_0000);
    i_sci_remote.send(9'h011, 8, 1'b1);
    @(posedge CLK);
    i_sci_remote.send(9'h022, 8, 1'b1);
    repeat (4) @(posedge CLK);
    chk("irq", 32'h0, 32'(IRQ));
    rd(STAT_OFS);
    chk("ovr", 32'h0000_000C, v & 32'h0000_006C);
    rd(DATA_OFS);
    chk("kept", 32'h0000_0011, v);
    $display("receive test done");
    // Sleep: address mark wakes first, then a quiet line
    wr(MASK_OFS, 32'h0000_0004);
    wr(CTRL_OFS, 32'h000F_001E);
    rxc(9'h055, 8, 1'b1, 8'h00, 1'b0);
    rxc(9'h0AA, 8, 1'b1, 8'h04, 1'b1);
    rd(CTRL_OFS);
    chk("awake", 32'h000F_000E, v);
    // Let the last idle event pass before sleeping on idle wakeup
    repeat (200) @(posedge CLK);
    wr(CTRL_OFS, 32'h000F_001C);
    wr(MASK_OFS, 32'h0000_0010);
    rd(STAT_OFS);
    rxc(9'h033, 8, 1'b1, 8'h00, 1'b0);
    repeat (170) @(posedge CLK);
    chk("irq", 32'h1, 32'(IRQ));
    rd(STAT_OFS);
    chk("idle", 32'h10, v & 32'h14);
    rd(CTRL_OFS);
    chk("woke", 32'h000F_000C, v);
    $display("wakeup test done");
    // 11-bit both ways; masked TX flags stay off the line
    wr(MASK_OFS, 32'h0000_0004);
    wr(CTRL_OFS, 32'h000F_000D);
    rxc(9'h1A5, 9, 1'b1, 8'h04, 1'b1);
    wr(DATA_OFS, 32'h0000_015A);
    i_sci_remote.grab(9, f);
    chk("tx9", 32'h0000_035A, 32'(f));
    repeat (20) @(posedge CLK);
    chk("irq", 32'h0, 32'(IRQ));
    rd(STAT_OFS);
    chk("txst", 32'h3, v & 32'h3);
    // Break frames, then normal frames once the bit is cleared
    wr(CTRL_OFS, 32'h000F_002C);
    i_sci_remote.grab(8, f);
    chk("brk", 32'h0, 32'(f));
    wr(CTRL_OFS, 32'h000F_000C);
    repeat (200) @(posedge CLK);
    wr(DATA_OFS, 32'h0000_0033);
    i_sci_remote.grab(8, f);
    chk("resume", 32'h0000_0133, 32'(f));
    rd(8'h10);
    chk("bad", 32'h0, v);
    chk("resp", 32'(RESP_SLVERR), 32'(rr));
    $display("link test done");
    report_and_stop();
  end
endmodule : sci_top_tb_top
